// ==== design/fsi_map.svh ====
// fault status and indicator block: offsets, field positions, codes and timing
// assumes a 100 MHz system clock and byte-wide register images
//
// Summary of operation
// - multi-byte words are little endian, low byte at lowest byte address
// - image byte positions count from zero
// - with no device, only the fault byte at position 2 reads defined
// - with no device, master commands are dropped, never forwarded
// - fault byte: device fault field bits 0-3, controller code bits 4-7
// - controller code 0x0 none, 0x4 no 24 V, 0x5 no device
// - controller code 0x9 while the fieldbus is not yet ready
// - code 0xC emergency stop, 0xE overcurrent; held until activation with the event gone
// - red indicator off without fault, lit on minor, blinking on major
// - blue indicator lit when powered and board running, else off
// - green off without network, blinking unconnected, lit when connected
`ifndef FSI_MAP_SVH
`define FSI_MAP_SVH

// ****************************************
// register image
// ****************************************
`define FSI_FAULT_OFS        8'h02
`define FSI_DEV_FIELD_LSB    0
`define FSI_CTRL_FIELD_LSB   4
`define FSI_FAULT_RESET      8'h00
`define FSI_IMG_BYTES        16

// ****************************************
// controller fault codes
// ****************************************
`define FSI_CODE_NONE        4'h0
`define FSI_CODE_NO_SUPPLY   4'h4
`define FSI_CODE_NO_DEVICE   4'h5
`define FSI_CODE_COMM_BOOT   4'h9
`define FSI_CODE_ESTOP       4'hc
`define FSI_CODE_OVERCURRENT 4'he

// ****************************************
// timing
// ****************************************
`define FSI_CLK_MHZ          100
`define FSI_BLINK_HALF_MS    250
`define FSI_BLINK_HALF_CYC   (`FSI_BLINK_HALF_MS * 1000 * `FSI_CLK_MHZ)

`endif

// ==== design/fsi_pkg.sv ====
// fault status and indicator block: shared types
// assumes fsi_map.svh supplies the numeric constants
package fsi_pkg;

  typedef struct packed {
    logic supplyOk;
    logic boardRunning;
    logic devicePresent;
    logic commReady;
    logic netDetected;
    logic connEstablished;
    logic estop;
    logic overcurrent;
  } fsi_status_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } fsi_cmd_type;

  typedef enum logic [1:0] {FSI_NONE, FSI_WARN, FSI_MINOR, FSI_MAJOR} fsi_class_type;

  typedef enum logic {FSI_RUN, FSI_HELD} fsi_major_type;

endpackage : fsi_pkg

// ==== design/fsi_status.sv ====
// fault status byte, command gate and status indicators
// assumes all inputs synchronous to clk; activate is a one-cycle pulse
`timescale 1ns/1ps
`include "fsi_map.svh"

module fsi_status
  import fsi_pkg::*;
#(
  parameter int IMG_BYTES         = `FSI_IMG_BYTES,
  parameter int BLINK_HALF_CYCLES = `FSI_BLINK_HALF_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire fsi_status_type            sts,
  input  wire logic [3:0]                devFault,
  input  wire logic [IMG_BYTES-1:0][7:0] devInImage,
  input  wire logic                      activate,
  input  wire fsi_cmd_type               cmdIn,
  input  wire logic                      rdEn,
  input  wire logic [7:0]                rdAddr,
  output fsi_cmd_type                    fwdCmd_q,
  output logic                           cmdDrop_q,
  output logic [15:0]                    rdData_q,
  output logic                           rdValid_q,
  output logic [7:0]                     faultStatus_q,
  output logic                           supplyLed_q,
  output logic                           commLed_q,
  output logic                           faultLed_q
);

  localparam int CW = $clog2(BLINK_HALF_CYCLES + 1);
  localparam logic [CW-1:0] BLINK_MAX = CW'(BLINK_HALF_CYCLES - 1);

  // ****************************************
  // major fault latch
  // ****************************************
  fsi_major_type majorState_q;
  logic [3:0]    majorCode_q;
  logic          majorEvent;

  assign majorEvent = sts.estop | sts.overcurrent;

  // a new event wins over activation in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      majorState_q <= FSI_RUN;
      majorCode_q  <= `FSI_CODE_NONE;
    end else begin
      case (majorState_q)
        FSI_RUN: begin
          if (majorEvent) begin
            majorState_q <= FSI_HELD;
            majorCode_q  <= sts.estop ? `FSI_CODE_ESTOP : `FSI_CODE_OVERCURRENT;
          end
        end
        FSI_HELD: begin
          if (activate && !majorEvent) begin
            majorState_q <= FSI_RUN;
            majorCode_q  <= `FSI_CODE_NONE;
          end
        end
        default: majorState_q <= FSI_RUN;
      endcase
    end
  end

  // ****************************************
  // controller fault code
  // ****************************************
  logic [3:0]    ctrlCode_d;
  fsi_class_type faultClass_d;
  fsi_class_type faultClass_q;

  // major over minor over warnings; no supply outranks no device
  always_comb begin
    ctrlCode_d   = `FSI_CODE_NONE;
    faultClass_d = FSI_NONE;
    if (majorState_q == FSI_HELD) begin
      ctrlCode_d   = majorCode_q;
      faultClass_d = FSI_MAJOR;
    end else if (!sts.commReady) begin
      ctrlCode_d   = `FSI_CODE_COMM_BOOT;
      faultClass_d = FSI_MINOR;
    end else if (!sts.supplyOk) begin
      ctrlCode_d   = `FSI_CODE_NO_SUPPLY;
      faultClass_d = FSI_WARN;
    end else if (!sts.devicePresent) begin
      ctrlCode_d   = `FSI_CODE_NO_DEVICE;
      faultClass_d = FSI_WARN;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      faultStatus_q <= `FSI_FAULT_RESET;
      faultClass_q  <= FSI_NONE;
    end else begin
      faultStatus_q[`FSI_CTRL_FIELD_LSB +: 4] <= ctrlCode_d;
      faultStatus_q[`FSI_DEV_FIELD_LSB +: 4]  <= sts.devicePresent ? devFault : 4'h0;
      faultClass_q  <= faultClass_d;
    end
  end

  // ****************************************
  // input image and read port
  // ****************************************
  logic [IMG_BYTES-1:0][7:0] imgByte;

  // without a device only the fault byte carries content
  for (genvar i = 0; i < IMG_BYTES; i++) begin : g_img
    assign imgByte[i] = (i == int'(`FSI_FAULT_OFS)) ? faultStatus_q :
                        (sts.devicePresent ? devInImage[i] : 8'h00);
  end

  logic [7:0] loByte;
  logic [7:0] hiByte;

  // zero-based positions; out-of-range bytes read as zero
  always_comb begin
    loByte = 8'h00;
    hiByte = 8'h00;
    if (int'(rdAddr) < IMG_BYTES) begin
      loByte = imgByte[rdAddr];
    end
    if (int'(rdAddr) + 1 < IMG_BYTES) begin
      hiByte = imgByte[rdAddr + 8'h01];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData_q  <= 16'h0000;
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= rdEn;
      if (rdEn) begin
        rdData_q <= {hiByte, loByte};
      end
    end
  end

  // ****************************************
  // command gate
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fwdCmd_q  <= '0;
      cmdDrop_q <= 1'b0;
    end else begin
      fwdCmd_q.valid <= cmdIn.valid && sts.devicePresent;
      fwdCmd_q.addr  <= cmdIn.addr;
      fwdCmd_q.data  <= cmdIn.data;
      cmdDrop_q      <= cmdIn.valid && !sts.devicePresent;
    end
  end

  // ****************************************
  // blink timebase
  // ****************************************
  logic [CW-1:0] blinkCnt_q;
  logic          blink_q;

  // one shared phase so both blinking indicators stay in step
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      blinkCnt_q <= '0;
      blink_q    <= 1'b0;
    end else if (blinkCnt_q == BLINK_MAX) begin
      blinkCnt_q <= '0;
      blink_q    <= ~blink_q;
    end else begin
      blinkCnt_q <= blinkCnt_q + CW'(1);
    end
  end

  // ****************************************
  // indicators
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      supplyLed_q <= 1'b0;
      commLed_q   <= 1'b0;
      faultLed_q  <= 1'b0;
    end else begin
      supplyLed_q <= sts.supplyOk && sts.boardRunning;
      if (!sts.netDetected) begin
        commLed_q <= 1'b0;
      end else if (!sts.connEstablished) begin
        commLed_q <= blink_q;
      end else begin
        commLed_q <= 1'b1;
      end
      case (faultClass_q)
        FSI_MINOR: faultLed_q <= 1'b1;
        FSI_MAJOR: faultLed_q <= blink_q;
        default:   faultLed_q <= 1'b0;
      endcase
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  dev_field_pos_a: assert property (
    $past(resetn) |-> faultStatus_q[3:0] == $past(sts.devicePresent ? devFault : 4'h0))
    else $error("device fault field misplaced");

  major_hold_a: assert property (
    (majorState_q == FSI_HELD && !activate) |=> majorState_q == FSI_HELD)
    else $error("major fault released without activation");

  estop_code_a: assert property (
    (majorState_q == FSI_RUN && sts.estop) |=> ##1 faultStatus_q[7:4] == 4'hc)
    else $error("emergency stop code missing");

  comm_boot_a: assert property (
    (majorState_q == FSI_RUN && !majorEvent && !sts.commReady) |=> faultStatus_q[7:4] == 4'h9)
    else $error("communication not ready code missing");

  cmd_block_a: assert property (
    (cmdIn.valid && !sts.devicePresent) |=> (!fwdCmd_q.valid && cmdDrop_q))
    else $error("command forwarded without device");

  cmd_pass_a: assert property (
    (cmdIn.valid && sts.devicePresent) |=> (fwdCmd_q.valid && fwdCmd_q.data == $past(cmdIn.data)))
    else $error("command not forwarded");

  no_dev_read_a: assert property (
    (rdEn && !sts.devicePresent && rdAddr != 8'h02) |=> rdData_q[7:0] == 8'h00)
    else $error("undefined byte read nonzero");

  little_end_a: assert property (
    (rdEn && rdAddr == 8'h01) |=> rdData_q[15:8] == $past(faultStatus_q))
    else $error("high byte not at next address");

  blink_toggle_a: assert property (
    (blinkCnt_q == BLINK_MAX) |=> blink_q != $past(blink_q))
    else $error("blink phase did not toggle");

  comm_led_on_a: assert property (
    (sts.netDetected && sts.connEstablished) |=> commLed_q)
    else $error("communication indicator not lit");

  fault_led_a: assert property (
    (faultClass_q == FSI_MINOR) |=> faultLed_q)
    else $error("fault indicator not lit on minor fault");

  major_clear_c: cover property (majorState_q == FSI_HELD ##[1:50] majorState_q == FSI_RUN);
  cmd_drop_c:    cover property (cmdDrop_q);
  blink_c:       cover property (faultClass_q == FSI_MAJOR && blinkCnt_q == BLINK_MAX);

endmodule : fsi_status

// ==== tb/fsi_master_model.sv ====
// fieldbus master model: reads, commands and activation
// assumes the bench calls its tasks; drives at falling edges
`timescale 1ns/1ps
module fsi_master_model
  import fsi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rdValid_q,
  input  wire logic [15:0] rdData_q,
  output logic             activate,
  output fsi_cmd_type      cmdIn,
  output logic             rdEn,
  output logic [7:0]       rdAddr
);
  initial begin
    activate = 1'b0;
    cmdIn = '0;
    rdEn = 1'b0;
    rdAddr = 8'h00;
  end
  // zero-based byte position, word comes low byte first
  task automatic readWord(input logic [7:0] a, output logic [15:0] d, output logic ok);
    @(negedge clk);
    rdEn = 1'b1;
    rdAddr = a;
    @(negedge clk);
    rdEn = 1'b0;
    rdAddr = ~a;
    ok = rdValid_q;
    d = rdData_q;
  endtask : readWord
  // released address and data flip, so no stale value looks valid
  task automatic sendCmd(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cmdIn = '{1'b1, a, d};
    @(negedge clk);
    cmdIn = '{1'b0, ~a, ~d};
  endtask : sendCmd
  // re-issued activation clears a held major fault once the event is gone
  task automatic doActivate;
    @(negedge clk);
    activate = 1'b1;
    @(negedge clk);
    activate = 1'b0;
  endtask : doActivate
endmodule : fsi_master_model

// ==== tb/fsi_status_tb_top.sv ====
// bench for the fault status block: scenarios, checks, verdict
// assumes the master model drives reads, commands and activation
`timescale 1ns/1ps
module fsi_status_tb_top
  import fsi_pkg::*;
;
  localparam logic [7:0] STS_TAB [7] = '{8'hf0, 8'h70, 8'hd0, 8'he0, 8'h40, 8'h50, 8'hb0};
  localparam logic [3:0] CODE_TAB [7] = '{4'h0, 4'h4, 4'h5, 4'h9, 4'h9, 4'h4, 4'h0};
  logic clk, resetn, activate, rdEn, rdValid_q, cmdDrop_q, ok;
  logic supplyLed_q, commLed_q, faultLed_q;
  fsi_status_type sts;
  fsi_cmd_type cmdIn, fwdCmd_q;
  logic [3:0] devFault;
  logic [15:0][7:0] devInImage;
  logic [7:0] rdAddr, faultStatus_q;
  logic [15:0] rdData_q, word, n;
  int error_cnt, check_count;

  fsi_status #(.BLINK_HALF_CYCLES(4)) i_fsi_status (.clk(clk), .resetn(resetn), .sts(sts),
    .devFault(devFault), .devInImage(devInImage), .activate(activate), .cmdIn(cmdIn), .rdEn(rdEn),
    .rdAddr(rdAddr), .fwdCmd_q(fwdCmd_q), .cmdDrop_q(cmdDrop_q), .rdData_q(rdData_q),
    .rdValid_q(rdValid_q), .faultStatus_q(faultStatus_q), .supplyLed_q(supplyLed_q),
    .commLed_q(commLed_q), .faultLed_q(faultLed_q));
  fsi_master_model i_fsi_master_model (.clk(clk), .rdValid_q(rdValid_q), .rdData_q(rdData_q),
    .activate(activate), .cmdIn(cmdIn), .rdEn(rdEn), .rdAddr(rdAddr));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic settle(input logic [7:0] s);
    @(negedge clk);
    sts = s;
    repeat (3) @(negedge clk);
  endtask : settle
  // eight samples span one whole blink period of the shortened count
  task automatic countLed(input logic comm, output logic [15:0] cnt);
    cnt = 16'h0;
    repeat (8) begin
      @(negedge clk);
      cnt = cnt + {15'h0, comm ? commLed_q : faultLed_q};
    end
  endtask : countLed
  task automatic t_codes;
    for (int i = 0; i < 7; i++) begin
      settle(STS_TAB[i]);
      chk({8'h0, faultStatus_q}, {8'h0, CODE_TAB[i], STS_TAB[i][5] ? 4'ha : 4'h0});
      chk({supplyLed_q, faultLed_q}, {STS_TAB[i][7] & STS_TAB[i][6], CODE_TAB[i] == 4'h9});
      i_fsi_master_model.readWord(8'h02, word, ok);
      chk({ok, word[7:0]}, {1'b1, CODE_TAB[i], STS_TAB[i][5] ? 4'ha : 4'h0});
    end
  endtask : t_codes
  task automatic t_image;
    settle(8'hf0);
    i_fsi_master_model.readWord(8'h00, word, ok);
    chk(word, 16'h3130);
    i_fsi_master_model.readWord(8'h0f, word, ok);
    chk(word, 16'h003f);
    settle(8'hd0);
    i_fsi_master_model.readWord(8'h01, word, ok);
    chk(word, 16'h5000);
  endtask : t_image
  task automatic t_cmd;
    settle(8'hf0);
    i_fsi_master_model.sendCmd(8'h05, 8'ha5);
    chk({fwdCmd_q.valid, cmdDrop_q, fwdCmd_q.data}, {2'b10, 8'ha5});
    chk({8'h0, fwdCmd_q.addr}, 16'h0005);
    settle(8'hd0);
    i_fsi_master_model.sendCmd(8'h05, 8'h5a);
    chk({fwdCmd_q.valid, cmdDrop_q}, 16'h1);
  endtask : t_cmd
  task automatic t_major;
    settle(8'hf2);
    chk({8'h0, faultStatus_q}, 16'h00ca);
    countLed(1'b0, n);
    chk(n, 16'h4);
    settle(8'hf2);
    i_fsi_master_model.doActivate();
    settle(8'hf0);
    chk({8'h0, faultStatus_q}, 16'h00ca);
    i_fsi_master_model.doActivate();
    repeat (3) @(negedge clk);
    chk({faultLed_q, faultStatus_q}, 16'h000a);
    settle(8'hf1);
    chk({8'h0, faultStatus_q}, 16'h00ea);
  endtask : t_major
  task automatic t_comm;
    settle(8'hf0);
    countLed(1'b1, n);
    chk(n, 16'h0);
    settle(8'hf8);
    countLed(1'b1, n);
    chk(n, 16'h4);
    settle(8'hfc);
    countLed(1'b1, n);
    chk(n, 16'h8);
  endtask : t_comm
  task automatic give_verdict;
    $display("Errors %0d, checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // about 155 cycles of scenarios; some thirty times that means a hang
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict();
  end
  initial begin
    resetn = 1'b0;
    sts = '0;
    devFault = 4'ha;
    error_cnt = 0;
    check_count = 0;
    for (int i = 0; i < 16; i++) devInImage[i] = 8'h30 + 8'(i);
    repeat (20) @(negedge clk);
    chk({8'h0, faultStatus_q}, 16'h0000);
    resetn = 1'b1;
    t_codes();
    t_image();
    t_cmd();
    t_major();
    t_comm();
    give_verdict();
  end
endmodule : fsi_status_tb_top
